// ### clock_mode_pkg.sv
// Constants, field layout and mode encoding of the clock mode controller.
// Assumes a classic Wishbone register bus and a single 200 MHz clock.
// Notes on behaviour
// - Running mode follows requested mode when conditions hold
// - Mode status updates several cycles after request
// - First write decides reference select, else locked
// - Mode encoding fixed; only bypassed external leaves self-clocked before stable
// - Self-clocked output ignores the reference frequency
// - Engaged external divides by 2R until first lock
// - Self-clocked and bypassed outputs divide source by R
// - Engaged internal loop target is ref/7*64*N
// - Engaged external target is ref*P*N; P by range
// - Multiplier code decodes to 4,6,8,10,12,14,16,18
// - Divider code decodes to 1,2,4,8,16,32,64,128
// - Fixed clock equals bus clock in bypassed external
// - Engaged external fixed clock is ref/2 when fast, locked
// - Fixed clock off in engaged internal and self-clocked
// - High gain bit selects high-gain oscillator
// - High gain only effective with reference select set
// - High gain bit writable once per reset
// - Reference ok only when reference meets minimum frequency, or bypassed external without reference select
package clock_mode_pkg;

	// ------------------------------------------------------------
	// Mode encoding
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		self_clocked_mode = 2'h0,
		loop_engaged_internal_mode = 2'h1,
		loop_bypassed_external_mode = 2'h2,
		loop_engaged_external_mode = 2'h3
	} mode_e;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] FIRST_CTRL_OFS = 4'h0;
	localparam logic [3:0] SECOND_CTRL_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int HIGH_GAIN_BIT = 7;
	localparam int RANGE_BIT = 6;
	localparam int REF_SEL_BIT = 5;
	localparam int MODE_REQ_LSB = 3;
	localparam int MULT_LSB = 4;
	localparam int DIV_LSB = 0;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_OSC_STABLE_BIT = 2;
	localparam int ST_EXT_OK_BIT = 3;
	localparam int ST_LOCK_BIT = 4;
	localparam int ST_LOSS_BIT = 5;
	localparam int ST_OFF_BIT = 6;
	localparam int ST_INIT_LOCK_BIT = 7;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] FIRST_CTRL_RST = 8'h00;
	localparam logic [7:0] SECOND_CTRL_RST = 8'h00;
	localparam logic [3:0] MODE_SETTLE_CYC = 4'h8;
	localparam logic [10:0] PRESCALE_LOW_RANGE = 11'h040;
	localparam logic [10:0] PRESCALE_HIGH_RANGE = 11'h001;
	localparam logic [2:0] INT_REF_DIVISOR = 3'h7;
	localparam logic [10:0] FIXED_MIN_RATIO = 11'h004;

	// Multiplier code to factor N: 4 plus twice the code
	function automatic logic [4:0] mult_factor(input logic [2:0] code);
		mult_factor = 5'h04 + {1'b0, code, 1'b0};
	endfunction

endpackage

// ### pulse_divider.sv
// Power-of-two divider of a one-cycle enable pulse train.
// Assumes the tick input is already in the clk domain.
`timescale 1ns/10ps
module pulse_divider #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic clear,
	input wire logic [3:0] shift,
	// Pulse in and out
	input wire logic tick,
	output logic pulse
);

	// ------------------------------------------------------------
	// Tick counter
	// ------------------------------------------------------------
	logic [WIDTH-1:0] count_reg; // Ticks seen in this period
	logic [WIDTH-1:0] limit; // Last count of the period

	// All-ones mask of the selected width
	assign limit = WIDTH'((1 << shift) - 1);
	assign pulse = tick && (count_reg >= limit);

	// Wraps at the limit; a shift change never strands the count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (clear) begin
			count_reg <= '0;
		end else if (pulse) begin
			count_reg <= '0;
		end else if (tick) begin
			count_reg <= count_reg + 1'b1;
		end
	end

endmodule // pulse_divider

// ### clock_mode_select.sv
// Clock mode selection, output divider and fixed-frequency clock.
// Assumes the loop, lock detector and clock monitors sit outside and
// report flags on this clock; oscillator clocks arrive as pins.
`timescale 1ns/10ps
module clock_mode_select #(
	parameter int REF_TIMEOUT_CYC = 8192,
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [clock_mode_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Oscillator pins
	input wire logic loop_osc_clock,
	input wire logic external_ref_clock,
	// Neighbour flags, same clock
	input wire logic osc_stable_flag,
	input wire logic lock_flag,
	input wire logic loss_of_clk_flag,
	input wire logic generator_off,
	// Clock outputs as enable pulses
	output logic generator_output_clock,
	output logic internal_system_clock,
	output logic fixed_freq_clock,
	// Oscillator and loop configuration
	output logic osc_amp_enable,
	output logic high_gain_osc,
	output logic [10:0] loop_mult,
	output logic [2:0] loop_ref_divisor
);
	import clock_mode_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] osc_sync_reg; // Loop oscillator: two stages and edge
	logic [2:0] ref_sync_reg; // External reference: two stages and edge
	logic osc_tick; // One pulse per loop oscillator period
	logic ref_tick; // One pulse per reference period

	// Bit 0 is read only by bit 1; edges are taken past the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_sync_reg <= 3'h0;
			ref_sync_reg <= 3'h0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[1:0], loop_osc_clock};
			ref_sync_reg <= {ref_sync_reg[1:0], external_ref_clock};
		end
	end
	assign osc_tick = osc_sync_reg[1] && !osc_sync_reg[2];
	assign ref_tick = ref_sync_reg[1] && !ref_sync_reg[2];

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	logic [7:0] first_control_register; // High gain, range, ref, mode
	logic [6:0] ctrl_low_reg; // Range, reference select, mode request
	logic high_gain_reg; // Stored high gain choice
	logic [7:0] second_control_register; // Multiplier and divider
	logic first_write_done_reg; // Control register written once
	logic ref_locked_reg; // Reference select held at zero
	logic high_gain_written_reg; // High gain bit already written
	logic bus_req; // New access this cycle
	logic wr_first; // Write to first control register
	logic wr_second; // Write to second control register
	logic [7:0] status_byte; // Live status view
	mode_e mode_status_field; // Running mode

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_first = bus_req && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i == FIRST_CTRL_OFS);
	assign wr_second = bus_req && wb_we_i && wb_sel_i[0] &&
		(wb_adr_i == SECOND_CTRL_OFS);

	// One-wait-state answer; unmapped reads return zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					FIRST_CTRL_OFS: wb_dat_o <= {24'h0, first_control_register};
					SECOND_CTRL_OFS: wb_dat_o <= {24'h0, second_control_register};
					STATUS_OFS: wb_dat_o <= {24'h0, status_byte};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic first_ref_ok; // First write asks for a crystal properly

	assign first_ref_ok = wb_dat_i[REF_SEL_BIT] && wb_dat_i[MODE_REQ_LSB+1];
	// Two owners, so each half of the register has its own flip-flops
	assign first_control_register = {high_gain_reg, ctrl_low_reg};

	// Mode request, range and reference select
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_low_reg <= FIRST_CTRL_RST[6:0];
			first_write_done_reg <= 1'b0;
			ref_locked_reg <= 1'b0;
		end else if (wr_first) begin
			ctrl_low_reg[6:MODE_REQ_LSB] <= wb_dat_i[6:MODE_REQ_LSB];
			ctrl_low_reg[2:0] <= 3'h0;
			first_write_done_reg <= 1'b1;
			if (!first_write_done_reg && !first_ref_ok) begin
				ref_locked_reg <= 1'b1;
				ctrl_low_reg[REF_SEL_BIT] <= 1'b0;
			end else if (ref_locked_reg || !first_write_done_reg) begin
				ctrl_low_reg[REF_SEL_BIT] <=
					wb_dat_i[REF_SEL_BIT] && !ref_locked_reg;
			end else begin
				ctrl_low_reg[REF_SEL_BIT] <= wb_dat_i[REF_SEL_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			high_gain_reg <= FIRST_CTRL_RST[HIGH_GAIN_BIT];
			high_gain_written_reg <= 1'b0;
		end else if (wr_first && !high_gain_written_reg) begin
			high_gain_reg <= wb_dat_i[HIGH_GAIN_BIT];
			high_gain_written_reg <= 1'b1;
		end
	end

	// Multiplier and divider codes; bit 3 and 7 are not kept
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			second_control_register <= SECOND_CTRL_RST;
		end else if (wr_second) begin
			second_control_register <= {1'b0, wb_dat_i[MULT_LSB+2:MULT_LSB],
				1'b0, wb_dat_i[DIV_LSB+2:DIV_LSB]};
		end
	end

	// ------------------------------------------------------------
	// Reference monitor
	// ------------------------------------------------------------
	logic [13:0] ref_gap_reg; // Cycles since the last reference edge
	logic ref_alive_reg; // Reference faster than the minimum
	logic ref_select; // Crystal requested
	mode_e mode_request_field; // Requested mode
	logic ext_ref_ok_flag; // Reference judged usable

	assign ref_select = first_control_register[REF_SEL_BIT];
	assign mode_request_field =
		mode_e'(first_control_register[MODE_REQ_LSB+1:MODE_REQ_LSB]);

	// Saturating gap counter; a gap past the timeout means too slow
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_gap_reg <= 14'h0;
			ref_alive_reg <= 1'b0;
		end else if (ref_tick) begin
			ref_gap_reg <= 14'h0;
			ref_alive_reg <= 1'b1;
		end else if (ref_gap_reg >= 14'(REF_TIMEOUT_CYC - 1)) begin
			ref_alive_reg <= 1'b0;
		end else begin
			ref_gap_reg <= ref_gap_reg + 14'h1;
		end
	end

	always_comb begin
		if (!mode_request_field[1]) begin
			ext_ref_ok_flag = 1'b0;
		end else if (mode_request_field == loop_bypassed_external_mode &&
			!ref_select) begin
			// External clock without oscillator: no monitoring
			ext_ref_ok_flag = 1'b1;
		end else begin
			ext_ref_ok_flag = ref_alive_reg;
		end
	end

	// ------------------------------------------------------------
	// Mode selection
	// ------------------------------------------------------------
	mode_e target_mode; // Mode the conditions allow now
	logic [3:0] settle_reg; // Cycles the target has differed

	always_comb begin
		case (mode_request_field)
			self_clocked_mode: target_mode = self_clocked_mode;
			loop_engaged_internal_mode: target_mode = osc_stable_flag ?
				loop_engaged_internal_mode : self_clocked_mode;
			loop_bypassed_external_mode: target_mode = ext_ref_ok_flag ?
				loop_bypassed_external_mode : self_clocked_mode;
			loop_engaged_external_mode: begin
				if (osc_stable_flag && ext_ref_ok_flag && !loss_of_clk_flag) begin
					target_mode = loop_engaged_external_mode;
				end else if (mode_status_field == loop_engaged_internal_mode &&
					osc_stable_flag) begin
					target_mode = loop_engaged_internal_mode;
				end else if (ext_ref_ok_flag) begin
					target_mode = loop_bypassed_external_mode;
				end else begin
					target_mode = self_clocked_mode;
				end
			end
			default: target_mode = self_clocked_mode;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_status_field <= self_clocked_mode;
			settle_reg <= 4'h0;
		end else if (target_mode == mode_status_field) begin
			settle_reg <= 4'h0;
		end else if (settle_reg == MODE_SETTLE_CYC - 4'h1) begin
			mode_status_field <= target_mode;
			settle_reg <= 4'h0;
		end else begin
			settle_reg <= settle_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Initial-lock tracking
	// ------------------------------------------------------------
	logic init_lock_reg; // Extra halving active
	logic in_engaged_ext; // Running engaged external

	assign in_engaged_ext = mode_status_field == loop_engaged_external_mode;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_lock_reg <= 1'b1;
		end else if (!in_engaged_ext || wr_second) begin
			// Re-arm on leaving the mode and on a multiplier change
			init_lock_reg <= 1'b1;
		end else if (lock_flag) begin
			init_lock_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Loop configuration
	// ------------------------------------------------------------
	logic [2:0] div_code; // Divider code
	logic [10:0] prescale; // Prescale factor P
	logic [10:0] pn_product; // P times N
	logic [10:0] four_r; // Four times R

	assign div_code = second_control_register[DIV_LSB+2:DIV_LSB];
	assign prescale = first_control_register[RANGE_BIT] ?
		PRESCALE_HIGH_RANGE : PRESCALE_LOW_RANGE;
	assign pn_product = 11'(prescale *
		{6'h00, mult_factor(second_control_register[MULT_LSB+2:MULT_LSB])});
	assign four_r = FIXED_MIN_RATIO << div_code;

	// internal ref over 7 times 64
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_mult <= 11'h0;
			loop_ref_divisor <= 3'h1;
		end else if (mode_status_field == loop_engaged_internal_mode) begin
			loop_mult <= {mult_factor(
				second_control_register[MULT_LSB+2:MULT_LSB]), 6'h00};
			loop_ref_divisor <= INT_REF_DIVISOR;
		end else begin
			loop_mult <= pn_product;
			loop_ref_divisor <= 3'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			high_gain_osc <= 1'b0;
			osc_amp_enable <= 1'b0;
		end else begin
			high_gain_osc <= first_control_register[HIGH_GAIN_BIT] && ref_select;
			osc_amp_enable <= ref_select && !ref_locked_reg;
		end
	end

	// ------------------------------------------------------------
	// Output divider
	// ------------------------------------------------------------
	logic src_tick; // Selected source clock
	logic [3:0] out_shift; // log2 of the division
	logic div_pulse; // Divided source

	assign src_tick = (mode_status_field == loop_bypassed_external_mode) ?
		ref_tick : osc_tick;
	// divider code is log2 of R
	assign out_shift = {1'b0, div_code} + {3'h0, in_engaged_ext && init_lock_reg};

	pulse_divider #(
		.WIDTH(DIV_W)
	) u_out_div (
		.clk(clk),
		.arst_n(arst_n),
		.clear(generator_off),
		.shift(out_shift),
		.tick(src_tick),
		.pulse(div_pulse)
	);

	// ------------------------------------------------------------
	// Output clocks
	// ------------------------------------------------------------
	logic bus_phase_reg; // Bus clock is half the generator output
	logic ref_phase_reg; // Reference halving for the fixed clock
	logic fixed_fast; // Ratio and lock allow the reference
	logic bus_tick; // Bus clock pulse this cycle

	assign bus_tick = div_pulse && bus_phase_reg;
	assign fixed_fast = (pn_product >= four_r) && lock_flag;

	// Phase toggles for the two halvings
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_phase_reg <= 1'b0;
			ref_phase_reg <= 1'b0;
		end else begin
			if (div_pulse) begin
				bus_phase_reg <= !bus_phase_reg;
			end
			if (ref_tick) begin
				ref_phase_reg <= !ref_phase_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			generator_output_clock <= 1'b0;
			internal_system_clock <= 1'b0;
			fixed_freq_clock <= 1'b0;
		end else if (generator_off) begin
			generator_output_clock <= 1'b0;
			internal_system_clock <= 1'b0;
			fixed_freq_clock <= 1'b0;
		end else begin
			generator_output_clock <= div_pulse;
			internal_system_clock <= bus_tick;
			case (mode_status_field)
				// off in engaged internal and self-clocked
				self_clocked_mode: fixed_freq_clock <= 1'b0;
				loop_engaged_internal_mode: fixed_freq_clock <= 1'b0;
				// reference over two when fast and locked
				loop_engaged_external_mode: fixed_freq_clock <= fixed_fast ?
					(ref_tick && ref_phase_reg) : bus_tick;
				default: fixed_freq_clock <= bus_tick;
			endcase
		end
	end

	assign status_byte = {init_lock_reg, generator_off, loss_of_clk_flag,
		lock_flag, ext_ref_ok_flag, osc_stable_flag, mode_status_field};

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_mode_write;
		wr_first;
	endsequence
	sequence s_off_held;
		generator_off [*2];
	endsequence

	a_status_not_immediate: assert property (
		s_mode_write |=> $stable(mode_status_field) [*2])
		else $error("mode status changed right after write");
	a_status_settle_count: assert property (
		$changed(mode_status_field) |->
		$past(settle_reg) == MODE_SETTLE_CYC - 4'h1)
		else $error("mode status moved without settle count");
	a_stay_self_clocked: assert property (
		mode_status_field == self_clocked_mode && !osc_stable_flag |=>
		mode_status_field inside {self_clocked_mode,
		loop_bypassed_external_mode})
		else $error("left self-clocked without stable oscillator");
	a_high_gain_once: assert property (
		s_mode_write ##0 high_gain_written_reg |=>
		$stable(first_control_register[HIGH_GAIN_BIT]))
		else $error("high gain bit changed on a second write");
	a_high_gain_valid: assert property (
		high_gain_osc |-> $past(ref_select))
		else $error("high gain active without reference select");
	a_ref_lock_amp: assert property (
		ref_locked_reg |=> !osc_amp_enable)
		else $error("amplifier enabled while reference locked");
	a_fixed_off: assert property (
		mode_status_field inside {self_clocked_mode,
		loop_engaged_internal_mode} |=> !fixed_freq_clock)
		else $error("fixed clock toggled in internal modes");
	a_off_quiet: assert property (
		s_off_held |-> !generator_output_clock && !fixed_freq_clock)
		else $error("output clock toggled in off state");
	a_ref_ok_alive: assert property (
		ref_select && mode_request_field[1] && !wr_first && !ref_tick &&
		ref_gap_reg >= 14'(REF_TIMEOUT_CYC - 1) |=> !ext_ref_ok_flag)
		else $error("reference ok without live reference");
	a_mult_decode: assert property (
		wr_second ##1 mode_status_field == loop_engaged_external_mode
		&& first_control_register[RANGE_BIT] |=>
		loop_mult == 11'(4 + 2 * $past(second_control_register[6:4])))
		else $error("multiplier decode wrong");

endmodule // clock_mode_select

// ### osc_source_model.sv
// Behavioural model of the crystal and loop oscillator pins.
// Assumes the bench only decides whether the reference runs.
`timescale 1ns/10ps
module osc_source_model #(
	parameter int LOOP_HALF_NS = 10,
	parameter int REF_HALF_NS = 30
) (
	// Control
	input wire logic ref_run,
	// Oscillator pins
	output logic loop_osc_clock,
	output logic external_ref_clock
);
	// Loop oscillator free runs, slower than clk/2 for the synchroniser
	initial loop_osc_clock = 1'b0;
	always #(LOOP_HALF_NS) loop_osc_clock = ~loop_osc_clock;
	// Reference stands still while stopped, as a dead crystal would
	initial external_ref_clock = 1'b0;
	always begin
		#(REF_HALF_NS);
		if (ref_run) begin
			external_ref_clock = ~external_ref_clock;
		end
	end
endmodule // osc_source_model

// ### clock_mode_select_bench.sv
// Self-checking bench: register accesses and clock pulse counting.
// Assumes the oscillator model drives the two pins of the block.
`timescale 1ns/10ps
module clock_mode_select_bench;
	import clock_mode_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rd;
	logic stable = 1'b0, lock = 1'b0, loss = 1'b0, off = 1'b0;
	logic ref_on = 1'b1;
	logic [31:0] dat_o;
	logic ack, lclk, rclk, gen, sys, fix, amp, hg;
	logic [10:0] mult;
	logic [2:0] rdiv;
	int num_errors = 0, checks = 0, cg, cs, cf, cr, i;
	bit cnt_en = 1'b0;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	osc_source_model osc (.ref_run(ref_on), .loop_osc_clock(lclk),
		.external_ref_clock(rclk));
	clock_mode_select #(.REF_TIMEOUT_CYC(64)) dut (.clk(clk),
		.arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .loop_osc_clock(lclk), .external_ref_clock(rclk),
		.osc_stable_flag(stable), .lock_flag(lock),
		.loss_of_clk_flag(loss), .generator_off(off),
		.generator_output_clock(gen), .internal_system_clock(sys),
		.fixed_freq_clock(fix), .osc_amp_enable(amp), .high_gain_osc(hg),
		.loop_mult(mult), .loop_ref_divisor(rdiv));
	// Pulse counters, enabled only inside a measuring window
	// fix only counted, never a clock
	always @(posedge clk) begin
		if (cnt_en) begin
			cg += gen;
			cs += sys;
			cf += fix;
		end
	end
	always @(posedge rclk) begin
		if (cnt_en) begin
			cr++;
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// Pulse rates drift with sync phase, so allow two counts of slack
	function automatic logic [31:0] near(input int a, input int b);
		near = {31'h0, (a <= b + 2) && (b <= a + 2)};
	endfunction
	// One classic cycle; request held until ack is sampled high
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
		end
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		check(rd & m, exp);
	endtask
	task automatic window(input int w);
		cg = 0;
		cs = 0;
		cf = 0;
		cr = 0;
		cnt_en = 1'b1;
		repeat (w) @(posedge clk);
		cnt_en = 1'b0;
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog, well beyond the expected run of about 10000 cycles
	initial begin
		#(400000ns);
		num_errors++;
		final_report();
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(4'h0, 32'hffffffff, 32'h0);
		rd_chk(4'h4, 32'hffffffff, 32'h0);
		rd_chk(4'hc, 32'hffffffff, 32'h0);
		// crystal kept: reference select and bypassed request
		xfer(1'b1, 4'h0, 8'hb0);
		rd_chk(4'h0, 32'hffffffff, 32'hb0);
		check(hg, 1'b1);
		check(amp, 1'b1);
		rd_chk(4'h8, 32'h3, 32'h0);
		repeat (30) @(posedge clk);
		rd_chk(4'h8, 32'h3, 32'h2);
		for (i = 0; i < 5; i++) begin
			xfer(1'b1, 4'h4, 8'(i));
			window(1200);
			check(near(cg, cr >> i), 32'h1);
			check(near(cf, cs), 32'h1);
		end
		xfer(1'b1, 4'h4, 8'h00);
		window(1200);
		check(near(cg, cr), 32'h1);
		// Dead reference: ok flag drops past the timeout, mode falls back
		ref_on <= 1'b0;
		repeat (120) @(posedge clk);
		rd_chk(4'h8, 32'hb, 32'h0);
		ref_on <= 1'b1;
		repeat (60) @(posedge clk);
		rd_chk(4'h8, 32'hb, 32'ha);
		xfer(1'b1, 4'h0, 8'h38);
		rd_chk(4'h0, 32'hffffffff, 32'hb8);
		repeat (30) @(posedge clk);
		rd_chk(4'h8, 32'h3, 32'h2);
		stable <= 1'b1;
		lock <= 1'b1;
		repeat (30) @(posedge clk);
		rd_chk(4'h8, 32'h3, 32'h3);
		check(mult, 11'h100);
		window(1200);
		check(near(cf, cr / 2), 32'h1);
		xfer(1'b1, 4'h0, 8'h78);
		// Loop setting is registered one edge after the write lands
		@(posedge clk);
		check(mult, 11'h004);
		for (i = 0; i < 5; i++) begin
			xfer(1'b1, 4'h4, 8'(i << 4));
			@(posedge clk);
			check(mult, 11'(4 + 2 * i));
		end
		xfer(1'b1, 4'h0, 8'h28);
		xfer(1'b1, 4'h8, 8'hff);
		repeat (30) @(posedge clk);
		rd_chk(4'h8, 32'h3, 32'h1);
		check(rdiv, 3'h7);
		check(mult, 11'h300);
		window(600);
		check(cf, 32'h0);
		off <= 1'b1;
		repeat (3) @(posedge clk);
		window(600);
		check(cg + cf + cs, 32'h0);
		// Second reset: a first write without a crystal locks the select
		arst_n <= 1'b0;
		off <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		xfer(1'b1, 4'h0, 8'h28);
		xfer(1'b1, 4'h0, 8'h30);
		rd_chk(4'h0, 32'hff, 32'h10);
		check(amp, 1'b0);
		final_report();
	end
endmodule // clock_mode_select_bench
